// [hw/psc_pkg.sv]
// Shared constants and carrier types for the program store control block.
// Assumes the core presents special register accesses and external-data moves
// as single-cycle strobes on the system clock.
`default_nettype none

package psc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PSC_CTL_ADDR = 8'h8F;   // Control register address
    localparam logic [7:0] PSC_CTL_PAGE = 8'h00;   // Special register page
    localparam logic [7:0] PSC_CTL_RESET = 8'h00;  // Control reset value
    localparam logic [7:0] PSC_CTL_USED = 8'h07;   // Implemented bits mask
    localparam logic [7:0] PSC_ZERO_BYTE = 8'h00;  // Data sent with an erase

    // Field positions
    localparam int PSC_WE_BIT = 0;                 // Flash write enable
    localparam int PSC_EE_BIT = 1;                 // Page erase enable
    localparam int PSC_SP_BIT = 2;                 // Scratchpad select

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Special register access from the core
    typedef struct packed {
        logic       wr;      // Write strobe
        logic       rd;      // Read strobe
        logic [7:0] page;    // Active register page
        logic [7:0] addr;    // Register address
        logic [7:0] wdata;   // Write data
    } psc_sfr_type;

    // External-data move from the core
    typedef struct packed {
        logic        wr;     // Move write strobe
        logic        rd;     // Move read strobe
        logic [15:0] addr;   // Effective address
        logic [7:0]  data;   // Write data
    } psc_move_type;

    // Steered memory request towards the memories
    typedef struct packed {
        logic        ram_wr;   // Write to external data space
        logic        ram_rd;   // Read from external data space
        logic        prog;     // Program one Flash byte
        logic        erase;    // Erase one Flash page
        logic        refused;  // Erase of the lock page was refused
        logic [15:0] addr;     // Target address
        logic [7:0]  data;     // Target data
    } psc_mem_type;

endpackage

`default_nettype wire

// [hw/psc_flash_ctl.sv]
// Program store control: control register plus steering of external-data
// moves to external RAM or to Flash programming and page erase.
// Assumes the core's strobes are one cycle wide and synchronous to mclk_i.
`timescale 1ns/1ns
`default_nettype none

module psc_flash_ctl #(
    parameter int ADDR_W = 16,                     // Move address width
    parameter int PAGE_BITS = 9,                   // Address bits inside one page
    parameter int LOCK_PAGE = 127                  // Page holding the lock bytes
) (
    input wire logic mclk_i,                       // System clock, 10 MHz
    input wire logic rst_n_i,                      // Synchronous reset, active low
    input wire psc_pkg::psc_sfr_type sfr_i,        // Control register access
    output logic [7:0] sfr_rdata_o,                // Control register read data
    input wire psc_pkg::psc_move_type move_i,      // External-data move
    output psc_pkg::psc_mem_type mem_o,            // Steered memory request
    output logic scratch_sel_o                     // Flash sector: 1 scratchpad
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ctl;                 // Implemented control bits
        logic [7:0] rdata;               // Registered read data
        psc_pkg::psc_mem_type mem;       // Registered memory request
    } psc_state_type;

    psc_state_type state_r;              // Current state
    psc_state_type state_nxt;            // Next state

    logic ctl_hit;                       // Access targets the control register
    logic lock_page;                     // Move address lies in the lock page
    logic [ADDR_W-PAGE_BITS-1:0] lock_idx; // Lock page number at page field width (ADDR_W-PAGE_BITS bits)

    assign lock_idx = (ADDR_W-PAGE_BITS)'(LOCK_PAGE);
    assign ctl_hit = (sfr_i.addr == psc_pkg::PSC_CTL_ADDR) &&
                     (sfr_i.page == psc_pkg::PSC_CTL_PAGE);
    assign lock_page = (move_i.addr[ADDR_W-1:PAGE_BITS] == lock_idx);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Register access, then steering of the move for this cycle
    always_comb begin
        state_nxt = state_r;
        state_nxt.mem.ram_wr = 1'b0;
        state_nxt.mem.ram_rd = 1'b0;
        state_nxt.mem.prog = 1'b0;
        state_nxt.mem.erase = 1'b0;
        state_nxt.mem.refused = 1'b0;
        // Only the low three bits are stored
        if (sfr_i.wr && ctl_hit) begin
            state_nxt.ctl = sfr_i.wdata[2:0];
        end
        // Read returns zero in the unused bits
        if (sfr_i.rd && ctl_hit) begin
            state_nxt.rdata = {5'h00, state_r.ctl} & psc_pkg::PSC_CTL_USED;
        end
        // Move reads always go to external data space
        if (move_i.rd) begin
            state_nxt.mem.ram_rd = 1'b1;
            state_nxt.mem.addr = move_i.addr;
        end
        if (move_i.wr) begin
            state_nxt.mem.addr = move_i.addr;
            state_nxt.mem.data = move_i.data;
            if (!state_r.ctl[psc_pkg::PSC_WE_BIT]) begin
                // Default target is external RAM
                state_nxt.mem.ram_wr = 1'b1;
            end else if (state_r.ctl[psc_pkg::PSC_EE_BIT]) begin
                // Data byte does not take part in an erase
                state_nxt.mem.data = psc_pkg::PSC_ZERO_BYTE;
                if (lock_page && !state_r.ctl[psc_pkg::PSC_SP_BIT]) begin
                    // Lock page is protected from software erase
                    state_nxt.mem.refused = 1'b1;
                end else begin
                    // Whole page erase instead of programming
                    state_nxt.mem.erase = 1'b1;
                end
            end else begin
                // Program one byte at the addressed location
                state_nxt.mem.prog = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset clears the control register and all strobes
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= '0;
            state_r.ctl <= psc_pkg::PSC_CTL_RESET[2:0];
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sfr_rdata_o = state_r.rdata;                   // Read data
    assign mem_o = state_r.mem;                           // Memory request
    assign scratch_sel_o = state_r.ctl[psc_pkg::PSC_SP_BIT]; // Sector

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic flash_wr;                       // Move write with Flash writes enabled
    logic erase_wr;                       // Move write with erase enabled
    assign flash_wr = move_i.wr && state_r.ctl[psc_pkg::PSC_WE_BIT];
    assign erase_wr = flash_wr && state_r.ctl[psc_pkg::PSC_EE_BIT];

    sequence s_erase_req;
        erase_wr && !(lock_page && !state_r.ctl[psc_pkg::PSC_SP_BIT]);
    endsequence

    sequence s_erase_done;
        mem_o.erase && !mem_o.prog && !mem_o.ram_wr;
    endsequence

    // Control register write taken this cycle
    sequence s_ctl_write;
        sfr_i.wr && ctl_hit;
    endsequence

    // Control register read taken this cycle
    sequence s_ctl_read;
        sfr_i.rd && ctl_hit;
    endsequence

    // Read right after a write returns the written low bits, upper bits zero
    property p_upper_zero;
        s_ctl_write ##1 s_ctl_read
            |=> sfr_rdata_o == {5'h00, $past(sfr_i.wdata[2:0], 2)};
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("Unused control bits read nonzero");

    property p_sector;
        s_ctl_write |=> scratch_sel_o == $past(sfr_i.wdata[psc_pkg::PSC_SP_BIT]);
    endproperty
    a_sector: assert property (p_sector)
        else $error("Sector select does not follow control write");

    property p_erase;
        s_erase_req |=> s_erase_done ##0 mem_o.addr == $past(move_i.addr);
    endproperty
    a_erase: assert property (p_erase)
        else $error("Erase enabled write did not erase");

    property p_erase_data;
        mem_o.erase |-> mem_o.data == psc_pkg::PSC_ZERO_BYTE;
    endproperty
    a_erase_data: assert property (p_erase_data)
        else $error("Erase carried the written data byte");

    property p_lock;
        erase_wr && lock_page && !state_r.ctl[psc_pkg::PSC_SP_BIT]
            |=> !mem_o.erase && mem_o.refused;
    endproperty
    a_lock: assert property (p_lock)
        else $error("Lock page erase was not refused");

    property p_prog;
        flash_wr && !state_r.ctl[psc_pkg::PSC_EE_BIT]
            |=> mem_o.prog && !mem_o.ram_wr && mem_o.data == $past(move_i.data);
    endproperty
    a_prog: assert property (p_prog)
        else $error("Flash write did not program the byte");

    property p_ram;
        move_i.wr && !state_r.ctl[psc_pkg::PSC_WE_BIT]
            |=> mem_o.ram_wr && !mem_o.prog && !mem_o.erase;
    endproperty
    a_ram: assert property (p_ram)
        else $error("Move write did not reach external RAM");

    property p_reset;
        @(posedge mclk_i) disable iff (1'b0)
        !rst_n_i |=> state_r.ctl == 3'h0 && !scratch_sel_o && !mem_o.prog;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Control register not cleared by reset");

    property p_read_ram;
        move_i.rd && !move_i.wr |=> mem_o.ram_rd && !mem_o.prog && !mem_o.erase;
    endproperty
    a_read_ram: assert property (p_read_ram)
        else $error("Move read did not go to external data space");

    // Sector select only moves on a control register write
    property p_sector_hold;
        !(sfr_i.wr && ctl_hit) |=> $stable(scratch_sel_o);
    endproperty
    a_sector_hold: assert property (p_sector_hold)
        else $error("Sector select changed without a control write");

    // Accesses to other registers leave control and read data untouched
    property p_unmapped;
        (sfr_i.wr || sfr_i.rd) && !ctl_hit
            |=> $stable(state_r.ctl) && $stable(sfr_rdata_o);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped access changed the control register");

    // A move write reaches exactly one target
    property p_one_target;
        move_i.wr && !move_i.rd
            |=> $onehot({mem_o.ram_wr, mem_o.prog, mem_o.erase, mem_o.refused});
    endproperty
    a_one_target: assert property (p_one_target)
        else $error("Move write did not reach exactly one target");

    // No move means no memory strobe
    property p_quiet;
        !move_i.wr && !move_i.rd
            |=> !mem_o.ram_wr && !mem_o.ram_rd && !mem_o.prog && !mem_o.erase;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Memory strobe without a move");

endmodule

`default_nettype wire

// [tb/psc_core_model.sv]
// Core-side model: issues control register accesses and external-data moves.
// Assumes one bench process calls its tasks; strobes stay up until the next call.
`timescale 1ns/1ns
`default_nettype none

module psc_core_model (
    input wire logic mclk_i,
    output psc_pkg::psc_sfr_type sfr_o,
    output psc_pkg::psc_move_type move_o
);
    // ------------------------------------------------------------------
    // Requests launch after a falling edge and stand over one rising edge
    // ------------------------------------------------------------------
    // Idle bus at time zero
    initial begin
        sfr_o = '0;
        move_o = '0;
    end

    // Register access; a released bus shows inverted leftovers, not old values
    task automatic sfr(input logic wr, input logic [7:0] pg, input logic [7:0] ad,
                       input logic [7:0] wd);
        @(negedge mclk_i);
        move_o = {2'h0, ~move_o.addr, ~move_o.data};
        sfr_o = {wr, ~wr, pg, ad, wd};
        @(posedge mclk_i);
    endtask

    // External-data move, write or read
    task automatic mv(input logic wr, input logic [15:0] ad, input logic [7:0] d);
        @(negedge mclk_i);
        sfr_o = {2'h0, sfr_o.page, ~sfr_o.addr, ~sfr_o.wdata};
        move_o = {wr, ~wr, ad, d};
        @(posedge mclk_i);
    endtask

    // Drop every strobe
    task automatic idle();
        @(negedge mclk_i);
        sfr_o = {2'h0, sfr_o.page, ~sfr_o.addr, ~sfr_o.wdata};
        move_o = {2'h0, ~move_o.addr, ~move_o.data};
    endtask
endmodule

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the program store control block.
// Assumes the core model drives the register and move inputs; notes are checked by a monitor.
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam int LOCK = 127;                       // Lock page number
    localparam logic [2:0] SEQ [8] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h7, 3'h5, 3'h6, 3'h4};
    logic mclk_i = 1'b0;                             // System clock
    logic rst_n_i = 1'b0;                            // Reset, active low
    psc_pkg::psc_sfr_type sfr;                       // Register access
    psc_pkg::psc_move_type mov;                      // Move request
    psc_pkg::psc_mem_type mem;                       // Steered request
    logic [7:0] rdata;                               // Register read data
    logic sel;                                       // Scratchpad sector
    logic hit;                                       // Read taken this edge
    logic [28:0] notes [$];                          // Expected results
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    // ------------------------------------------------------------------
    // Clock, instances
    // ------------------------------------------------------------------
    initial forever #50 mclk_i = ~mclk_i;
    psc_core_model psc_core_model_i (.mclk_i(mclk_i), .sfr_o(sfr), .move_o(mov));
    psc_flash_ctl #(.ADDR_W(16), .PAGE_BITS(9), .LOCK_PAGE(LOCK)) psc_flash_ctl_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
        .move_i(mov), .mem_o(mem), .scratch_sel_o(sel));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [28:0] seen, input logic [28:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [28:0] pop();
        if (notes.size() == 0) return 'x;
        return notes.pop_front();
    endfunction
    // Expected strobe, address and data of one move under control value c
    function automatic logic [28:0] mv_exp(logic [2:0] c, logic wr, logic [15:0] a,
                                           logic [7:0] d);
        if (!wr) return {5'h08, a, 8'h00};
        if (!c[0]) return {5'h10, a, d};
        if (!c[1]) return {5'h04, a, d};
        if (a[15:9] == 7'(LOCK) && !c[2]) return {5'h01, a, 8'h00};
        return {5'h02, a, 8'h00};
    endfunction
    task automatic rd_ctl(input logic [7:0] exp);
        notes.push_back({21'h0, exp});
        psc_core_model_i.sfr(1'b0, psc_pkg::PSC_CTL_PAGE, psc_pkg::PSC_CTL_ADDR, 8'h00);
    endtask
    task automatic move(input logic [2:0] c, input logic wr, input logic [15:0] a,
                        input logic [7:0] d);
        notes.push_back(mv_exp(c, wr, a, d));
        psc_core_model_i.mv(wr, a, d);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge mclk_i) begin
        hit = sfr.rd && sfr.page === psc_pkg::PSC_CTL_PAGE && sfr.addr === psc_pkg::PSC_CTL_ADDR;
        #1;
        if (|mem[28:24]) chk({mem[28:8], mem.ram_rd ? 8'h00 : mem.data}, pop());
        if (hit) chk({21'h0, rdata}, pop());
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [7:0] d;
        void'($urandom(7501));
        repeat (20) @(negedge mclk_i);
        rst_n_i = 1'b1;
        @(posedge mclk_i);
        // Reset state: control clear, moves go to external data space
        rd_ctl(8'h00);
        #1 chk({28'h0, sel}, 29'h0);
        move(3'h0, 1'b1, 16'h1234, 8'h55);
        move(3'h0, 1'b0, 16'h1234, 8'h00);
        $display("reset test done");
        // Every control value, erase ahead of programming at one address per scratchpad setting
        a = 16'($urandom);
        foreach (SEQ[i]) begin
            d = 8'($urandom);
            psc_core_model_i.sfr(1'b1, 8'h00, psc_pkg::PSC_CTL_ADDR, {d[7:3], SEQ[i]});
            rd_ctl({5'h00, SEQ[i]});
            #1 chk({28'h0, sel}, {28'h0, SEQ[i][2]});
            a = SEQ[i][2] ? {9'h000, a[6:0]} : a;
            move(SEQ[i], 1'b1, a, d);
            move(SEQ[i], 1'b0, a, d);
        end
        $display("control sweep done");
        // Erase aimed at the lock page, then unmapped accesses
        psc_core_model_i.sfr(1'b1, 8'h00, psc_pkg::PSC_CTL_ADDR, 8'h03);
        move(3'h3, 1'b1, {7'(LOCK), 9'h1AB}, 8'hA5);
        psc_core_model_i.sfr(1'b1, 8'h01, psc_pkg::PSC_CTL_ADDR, 8'h04);
        psc_core_model_i.sfr(1'b1, 8'h00, 8'h8E, 8'h04);
        psc_core_model_i.sfr(1'b0, 8'h00, 8'h8E, 8'h00);
        #1 chk({21'h0, rdata}, 29'h004);
        rd_ctl(8'h03);
        psc_core_model_i.idle();
        repeat (3) @(posedge mclk_i);
        $display("lock and unmapped test done");
        // Reset in mid-run clears a control value with the scratchpad selected
        psc_core_model_i.sfr(1'b1, 8'h00, psc_pkg::PSC_CTL_ADDR, 8'h05);
        #1 chk({28'h0, sel}, 29'h1);
        psc_core_model_i.idle();
        rst_n_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        @(posedge mclk_i);
        rd_ctl(8'h00);
        #1 chk({28'h0, sel}, 29'h0);
        move(3'h0, 1'b1, 16'h0ABC, 8'h3C);
        psc_core_model_i.idle();
        repeat (2) @(posedge mclk_i);
        chk(29'(notes.size()), 29'h0);
        $display("mid-run reset test done");
        summarize();
    end
endmodule

`default_nettype wire
